/* sram_jtag_test_access_port_test.sv */
// Self-checking bench for the memory test access port
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module sram_jtag_test_access_port_test;
  import stap_pkg::*;
  localparam int BL = STAP_BSR_LEN;
  localparam logic [31:0] ID_EXP = {STAP_ID_REVISION, STAP_ID_PART, STAP_ID_VENDOR, 1'b1};
  logic clk_sys, rst, tck, tms, tdi, tdo, tdo_oe_n, tap_reset, so, so2;
  logic [BL-1:0] ring_in;
  logic [BL-1:0] got;
  logic [STAP_IR_LEN-1:0] instr;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;

  stap_top #(.BSR_LEN(BL)) dut (.clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .ring_in(ring_in), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .instr(instr), .tap_reset(tap_reset));
  stap_jtag_host host (.clk_sys(clk_sys), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic clk_bit(input logic m, input logic d);
    host.step(m, d, so, so2);
    `CHK("tdo held over high phase", so, so2)
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    `CHK("instr after reset", STAP_OP_IDCODE, instr)
    `CHK("tap_reset after reset", 1'b1, tap_reset)
    `CHK("tdo_oe_n after reset", 1'b1, tdo_oe_n)
    `CHK("tdo after reset", 1'b0, tdo)
  endtask
  // From idle: capture, shift n bits, update, back to idle
  task automatic shift_dr(input int n, input logic [BL-1:0] din, output logic [BL-1:0] dout);
    dout = '0;
    clk_bit(1'b1, 1'b0);
    clk_bit(1'b0, 1'b0);
    clk_bit(1'b0, 1'b0);
    repeat (6) @(negedge clk_sys);
    `CHK("oe_n while shifting", 1'b0, tdo_oe_n)
    for (int i = 0; i < n; i++) begin
      clk_bit(i == n - 1, din[i]);
      dout[i] = so;
    end
    clk_bit(1'b1, 1'b0);
    clk_bit(1'b0, 1'b0);
    repeat (6) @(negedge clk_sys);
    `CHK("oe_n in idle", 1'b1, tdo_oe_n)
    `CHK("tdo in idle", 1'b0, tdo)
  endtask
  task automatic load_ir(input logic [2:0] op);
    clk_bit(1'b1, 1'b0);
    clk_bit(1'b1, 1'b0);
    clk_bit(1'b0, 1'b0);
    clk_bit(1'b0, 1'b0);
    for (int i = 0; i < STAP_IR_LEN; i++) begin
      clk_bit(i == STAP_IR_LEN - 1, op[i]);
      `CHK("ir capture bit", STAP_IR_CAPTURE[i], so)
    end
    clk_bit(1'b1, 1'b0);
    clk_bit(1'b0, 1'b0);
    `CHK("instr after update", op, instr)
  endtask
  task automatic read_id();
    clk_bit(1'b0, 1'b0);
    shift_dr(32, '0, got);
    `CHK("id code", ID_EXP, got[31:0])
  endtask
  // Bypass ops and unknown ops that fall back to bypass
  task automatic bypass_ops();
    logic [2:0] ops [4] = '{3'h3, 3'h5, 3'h6, STAP_OP_BYPASS};
    logic [BL-1:0] din;
    foreach (ops[k]) begin
      din = '0;
      din[7:0] = 8'hB4 ^ {5'h0, ops[k]};
      load_ir(ops[k]);
      shift_dr(9, din, got);
      `CHK("bypass path", {din[7:0], 1'b0}, got[8:0])
    end
  endtask
  task automatic boundary_ops();
    logic [2:0] ops [3] = '{STAP_OP_EXTEST, STAP_OP_SAMPLE_Z, STAP_OP_SAMPLE};
    clk_bit(1'b0, 1'b0);
    foreach (ops[k]) begin
      ring_in = BL'({4{32'hC3A5_0F96}});
      ring_in[2:0] = ops[k];
      ring_in[BL-1] = ~ops[k][1];
      load_ir(ops[k]);
      shift_dr(BL, '0, got);
      `CHK("boundary capture", ring_in, got)
    end
  endtask
  // Five mode-select-high rises from Shift-IR, the longest way to reset
  task automatic tms_reset();
    load_ir(STAP_OP_BYPASS);
    clk_bit(1'b1, 1'b0);
    clk_bit(1'b1, 1'b0);
    clk_bit(1'b0, 1'b0);
    clk_bit(1'b0, 1'b1);
    repeat (4) clk_bit(1'b1, 1'b1);
    `CHK("tap_reset after four", 1'b0, tap_reset)
    clk_bit(1'b1, 1'b1);
    `CHK("tap_reset after five", 1'b1, tap_reset)
    `CHK("instr after five", STAP_OP_IDCODE, instr)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    ring_in = '0;
    do_reset();
    read_id();
    bypass_ops();
    do_reset();
    boundary_ops();
    tms_reset();
    read_id();
    tally_and_finish();
  end
endmodule

/* stap_jtag_host.sv */
// Far-side controller model that clocks the memory test port
`timescale 1ns/10ps
module stap_jtag_host (
  input wire logic clk_sys,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  // Test clock stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One 160 ns test clock period; inputs change with the fall, tdo is sampled
  // just before the rise and again just before the next fall
  task automatic step(input logic m, input logic d, output logic o_rise, output logic o_fall);
    tms = m;
    tdi = d;
    repeat (8) @(negedge clk_sys);
    o_rise = tdo;
    tck = 1'b1;
    repeat (8) @(negedge clk_sys);
    o_fall = tdo;
    tck = 1'b0;
  endtask
endmodule

/* stap_pkg.sv */
// Package: constants and types for the memory test access port
package stap_pkg;

  // Serial register lengths, synchroniser depth and reset edge count
  localparam int STAP_IR_LEN = 3;
  localparam int STAP_ID_LEN = 32;
  localparam int STAP_BSR_LEN = 107;
  localparam int STAP_SYNC_STAGES = 2;
  localparam int STAP_RESET_TMS_EDGES = 5;

  // Instruction opcodes
  localparam logic [2:0] STAP_OP_EXTEST = 3'h0;
  localparam logic [2:0] STAP_OP_IDCODE = 3'h1;
  localparam logic [2:0] STAP_OP_SAMPLE_Z = 3'h2;
  localparam logic [2:0] STAP_OP_SAMPLE = 3'h4;
  localparam logic [2:0] STAP_OP_BYPASS = 3'h7;

  // Value after reset and the fixed capture pattern of the instruction path
  localparam logic [2:0] STAP_IR_RESET = STAP_OP_IDCODE;
  localparam logic [2:0] STAP_IR_CAPTURE = 3'h1;

  // Identification code fields; the values are arbitrary
  localparam logic [3:0] STAP_ID_REVISION = 4'h0;
  localparam logic [15:0] STAP_ID_PART = 16'h1234;
  localparam logic [10:0] STAP_ID_VENDOR = 11'h055;

  typedef enum logic [3:0] {
    STAP_TLR, STAP_RTI, STAP_SEL_DR, STAP_CAP_DR, STAP_SHF_DR, STAP_EX1_DR,
    STAP_PAU_DR, STAP_EX2_DR, STAP_UPD_DR, STAP_SEL_IR, STAP_CAP_IR,
    STAP_SHF_IR, STAP_EX1_IR, STAP_PAU_IR, STAP_EX2_IR, STAP_UPD_IR
  } stap_state_t;

  // Serial path selection
  typedef enum logic [1:0] {
    STAP_PATH_IR, STAP_PATH_BYP, STAP_PATH_ID, STAP_PATH_BSR
  } stap_path_t;

  // Test pins as sampled into the system clock
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } stap_pins_t;

endpackage

/* stap_sync.sv */
// Two-stage synchroniser for the test pins
`timescale 1ns/10ps
module stap_sync
  import stap_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire stap_pins_t pins_async,
  output stap_pins_t pins_sync
);

  stap_pins_t meta_q;
  stap_pins_t sync_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins_async;
      sync_q <= meta_q;
    end
  end

  assign pins_sync = sync_q;

endmodule

/* stap_top.sv */
// Test access port of the memory device, sampled on the system clock
`timescale 1ns/10ps
module stap_top
  import stap_pkg::*;
#(
  parameter int BSR_LEN = STAP_BSR_LEN
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic [BSR_LEN-1:0] ring_in,
  output logic tdo,
  output logic tdo_oe_n,
  output logic [STAP_IR_LEN-1:0] instr,
  output logic tap_reset
);

  if (BSR_LEN < 1) begin : g_bad_len
    $error("BSR_LEN must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and test clock edges

  stap_pins_t pins_raw;
  stap_pins_t pins_s;
  logic tck_q;

  assign pins_raw = '{tck: tck, tms: tms, tdi: tdi};

  stap_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pins_async(pins_raw),
    .pins_sync(pins_s)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tck_q <= 1'b0;
    end else begin
      tck_q <= pins_s.tck;
    end
  end

  // Edges are seen two system clocks late; very short test clock phases are lost
  wire tck_rise = pins_s.tck & ~tck_q;
  wire tck_fall = ~pins_s.tck & tck_q;

  ////////////////////////////////////////////////////////////////////////////
  // State machine, stepped by mode select only

  stap_state_t state_q;
  stap_state_t state_d;
  wire t = pins_s.tms;

  always_comb begin
    case (state_q)
      STAP_TLR: state_d = t ? STAP_TLR : STAP_RTI;
      STAP_RTI: state_d = t ? STAP_SEL_DR : STAP_RTI;
      STAP_SEL_DR: state_d = t ? STAP_SEL_IR : STAP_CAP_DR;
      STAP_CAP_DR: state_d = t ? STAP_EX1_DR : STAP_SHF_DR;
      STAP_SHF_DR: state_d = t ? STAP_EX1_DR : STAP_SHF_DR;
      STAP_EX1_DR: state_d = t ? STAP_UPD_DR : STAP_PAU_DR;
      STAP_PAU_DR: state_d = t ? STAP_EX2_DR : STAP_PAU_DR;
      STAP_EX2_DR: state_d = t ? STAP_UPD_DR : STAP_SHF_DR;
      STAP_UPD_DR: state_d = t ? STAP_SEL_DR : STAP_RTI;
      STAP_SEL_IR: state_d = t ? STAP_TLR : STAP_CAP_IR;
      STAP_CAP_IR: state_d = t ? STAP_EX1_IR : STAP_SHF_IR;
      STAP_SHF_IR: state_d = t ? STAP_EX1_IR : STAP_SHF_IR;
      STAP_EX1_IR: state_d = t ? STAP_UPD_IR : STAP_PAU_IR;
      STAP_PAU_IR: state_d = t ? STAP_EX2_IR : STAP_PAU_IR;
      STAP_EX2_IR: state_d = t ? STAP_UPD_IR : STAP_SHF_IR;
      STAP_UPD_IR: state_d = t ? STAP_SEL_DR : STAP_RTI;
      default: state_d = STAP_TLR;
    endcase
  end

  // System reset stands in for power-up
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= STAP_TLR;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register

  logic [STAP_IR_LEN-1:0] ir_sh_q;
  logic [STAP_IR_LEN-1:0] ir_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ir_sh_q <= STAP_IR_CAPTURE;
      ir_q <= STAP_IR_RESET;
    end else if (tck_rise) begin
      if (state_q == STAP_CAP_IR) begin
        ir_sh_q <= STAP_IR_CAPTURE;
      end else if (state_q == STAP_SHF_IR) begin
        ir_sh_q <= {pins_s.tdi, ir_sh_q[STAP_IR_LEN-1:1]};
      end
      // Entering or staying in reset reloads the instruction at once
      if (state_d == STAP_TLR) begin
        ir_q <= STAP_IR_RESET;
      end else if (state_q == STAP_UPD_IR) begin
        ir_q <= ir_sh_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data path decode: unknown opcodes fall back to bypass

  stap_path_t dr_path;
  wire is_bsr = (ir_q == STAP_OP_EXTEST) | (ir_q == STAP_OP_SAMPLE) |
                (ir_q == STAP_OP_SAMPLE_Z);
  wire is_id = (ir_q == STAP_OP_IDCODE);

  assign dr_path = is_bsr ? STAP_PATH_BSR : (is_id ? STAP_PATH_ID : STAP_PATH_BYP);

  wire ir_state = (state_q == STAP_CAP_IR) | (state_q == STAP_SHF_IR) |
                  (state_q == STAP_EX1_IR) | (state_q == STAP_PAU_IR) |
                  (state_q == STAP_EX2_IR) | (state_q == STAP_UPD_IR);
  stap_path_t path;
  assign path = ir_state ? STAP_PATH_IR : dr_path;

  wire cap_dr = (state_q == STAP_CAP_DR);
  wire shf_dr = (state_q == STAP_SHF_DR);

  ////////////////////////////////////////////////////////////////////////////
  // Data registers

  logic byp_q;
  logic [STAP_ID_LEN-1:0] id_q;
  logic [BSR_LEN-1:0] bsr_q;
  wire [STAP_ID_LEN-1:0] id_code = {STAP_ID_REVISION, STAP_ID_PART, STAP_ID_VENDOR, 1'b1};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      byp_q <= 1'b0;
      id_q <= '0;
    end else if (tck_rise) begin
      if (cap_dr && path == STAP_PATH_BYP) begin
        byp_q <= 1'b0;
      end else if (shf_dr && path == STAP_PATH_BYP) begin
        byp_q <= pins_s.tdi;
      end
      if (cap_dr && path == STAP_PATH_ID) begin
        id_q <= id_code;
      end else if (shf_dr && path == STAP_PATH_ID) begin
        id_q <= {pins_s.tdi, id_q[STAP_ID_LEN-1:1]};
      end
    end
  end

  // Boundary cell i holds bump ring_in[i]; cell 0 is nearest the output
  genvar gi;
  generate
    for (gi = 0; gi < BSR_LEN; gi++) begin : g_bsr
      wire next_bit;
      if (gi == BSR_LEN - 1) begin : g_last
        assign next_bit = pins_s.tdi;
      end else begin : g_mid
        assign next_bit = bsr_q[gi+1];
      end
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          bsr_q[gi] <= 1'b0;
        end else if (tck_rise && path == STAP_PATH_BSR) begin
          if (cap_dr) begin
            bsr_q[gi] <= ring_in[gi];
          end else if (shf_dr) begin
            bsr_q[gi] <= next_bit;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Serial output, moved on the falling test clock edge; instr and tap_reset follow on every system clock

  logic sel_bit;
  always_comb begin
    case (path)
      STAP_PATH_IR: sel_bit = ir_sh_q[0];
      STAP_PATH_ID: sel_bit = id_q[0];
      STAP_PATH_BSR: sel_bit = bsr_q[0];
      default: sel_bit = byp_q;
    endcase
  end
  wire shifting = shf_dr | (state_q == STAP_SHF_IR);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tdo <= 1'b0;
      tdo_oe_n <= 1'b1;
      instr <= STAP_IR_RESET;
      tap_reset <= 1'b1;
    end else begin
      if (tck_fall) begin
        tdo <= shifting ? sel_bit : 1'b0;
        tdo_oe_n <= ~shifting;
      end
      instr <= ir_q;
      tap_reset <= (state_q == STAP_TLR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  localparam logic [2:0] RST_EDGES = 3'(STAP_RESET_TMS_EDGES);
  logic [2:0] tms_hi_cnt;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tms_hi_cnt <= '0;
    end else if (tck_rise) begin
      tms_hi_cnt <= pins_s.tms ? (tms_hi_cnt == RST_EDGES ? RST_EDGES : tms_hi_cnt + 3'h1) : 3'h0;
    end
  end

  five_tms_reset_a: assert property (@(posedge clk_sys) disable iff (rst)
    tms_hi_cnt == RST_EDGES |-> state_q == STAP_TLR)
    else $error("five high mode-select edges did not reset");
  state_on_rise_a: assert property (@(posedge clk_sys) disable iff (rst)
    !tck_rise |=> $stable(state_q))
    else $error("state moved without a test clock rise");
  tdo_on_fall_a: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(tck_fall) |-> $stable(tdo))
    else $error("serial output moved without a falling edge");
  oe_shift_only_a: assert property (@(posedge clk_sys) disable iff (rst)
    tck_fall && !shifting |=> tdo_oe_n)
    else $error("serial output enabled outside shift");
  ir_reset_id_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == STAP_TLR |-> ir_q == STAP_OP_IDCODE)
    else $error("identification instruction not loaded in reset state");
  ir_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(tck_rise && (state_q == STAP_UPD_IR || state_d == STAP_TLR)) |=> $stable(ir_q))
    else $error("instruction changed outside update");
  byp_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    tck_rise && cap_dr && path == STAP_PATH_BYP |=> !byp_q)
    else $error("bypass cell did not capture zero");
  id_capture_a: assert property (@(posedge clk_sys) disable iff (rst)
    tck_rise && cap_dr && is_id |=> id_q == id_code)
    else $error("identification code not captured");
  bsr_capture_a: assert property (@(posedge clk_sys) disable iff (rst)
    tck_rise && cap_dr && is_bsr |=> bsr_q == $past(ring_in))
    else $error("boundary register did not capture the ring");
  path_ir_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == STAP_SHF_IR |-> path == STAP_PATH_IR)
    else $error("instruction path not selected in shift-IR");
  path_bsr_sel_a: assert property (@(posedge clk_sys) disable iff (rst)
    shf_dr && is_bsr |-> path == STAP_PATH_BSR)
    else $error("boundary path not selected for a boundary instruction");
  tdo_idle_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    tdo_oe_n |-> !tdo)
    else $error("serial output not zero while disabled");
  oe_shift_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    tck_fall && shifting |=> !tdo_oe_n)
    else $error("serial output not enabled while shifting");
  tdo_value_a: assert property (@(posedge clk_sys) disable iff (rst)
    tck_fall && shifting |=> tdo == $past(sel_bit))
    else $error("serial output does not show the selected bit");
  bsr_shift_in_a: assert property (@(posedge clk_sys) disable iff (rst)
    tck_rise && shf_dr && path == STAP_PATH_BSR |=> bsr_q[BSR_LEN-1] == $past(pins_s.tdi))
    else $error("boundary register did not take the serial input");
  byp_shift_in_a: assert property (@(posedge clk_sys) disable iff (rst)
    tck_rise && shf_dr && path == STAP_PATH_BYP |=> byp_q == $past(pins_s.tdi))
    else $error("bypass cell did not take the serial input");
  id_shift_in_a: assert property (@(posedge clk_sys) disable iff (rst)
    tck_rise && shf_dr && path == STAP_PATH_ID |=> id_q[STAP_ID_LEN-1] == $past(pins_s.tdi))
    else $error("identification register did not take the serial input");
  ir_sh_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(tck_rise && (state_q == STAP_SHF_IR || state_q == STAP_CAP_IR)) |=> $stable(ir_sh_q))
    else $error("instruction shifter moved while not selected");
  instr_out_a: assert property (@(posedge clk_sys) disable iff (rst)
    instr == $past(ir_q))
    else $error("instruction output does not follow the held instruction");
  tap_reset_out_a: assert property (@(posedge clk_sys) disable iff (rst)
    tap_reset == $past(state_q == STAP_TLR))
    else $error("reset state flag does not follow the state");
  tlr_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    tck_rise && state_q == STAP_TLR && pins_s.tms |=> state_q == STAP_TLR)
    else $error("reset state left with mode select high");

endmodule
